/* fupc_pkg.sv */
// flash user-program control: shared constants, types and field layouts
// assumes a cpu register port, option byte strap and a flash macro beside it
package fupc_pkg;
	// register addresses on the cpu register port
	localparam logic [7:0] ADDR_FLASH_OP_CONTROL = 8'hf9;
	localparam logic [7:0] ADDR_USER_PROGRAM_KEY = 8'hf8;
	localparam logic [7:0] ADDR_SECTOR_BASE_HIGH = 8'hfa;
	localparam logic [7:0] ADDR_SECTOR_BASE_LOW  = 8'hfb;
	localparam logic [7:0] KEY_VALUE             = 8'ha5;
	localparam logic [7:0] RESET_BYTE            = 8'h00;
	// control fields
	localparam int         CTL_MODE_LSB          = 4;
	localparam int         CTL_STATUS_BIT        = 3;
	localparam int         CTL_START_BIT         = 0;
	localparam logic [3:0] MODE_PROGRAM          = 4'h5;
	localparam logic [3:0] MODE_HARD_LOCK        = 4'h6;
	localparam logic [3:0] MODE_SECTOR_ERASE     = 4'ha;
	// memory layout
	localparam int         SECTOR_BITS           = 7;
	localparam logic [8:0] SECTOR_COUNT          = 9'd384;
	localparam logic [15:0] BOOT_START           = 16'h0100;
	localparam logic [15:0] BOOT_END_256         = 16'h01ff;
	localparam logic [15:0] BOOT_END_512         = 16'h02ff;
	localparam logic [15:0] BOOT_END_1K          = 16'h04ff;
	localparam logic [15:0] BOOT_END_2K          = 16'h08ff;
	localparam logic [15:0] VEC_DEFAULT          = 16'h0100;
	localparam logic [15:0] VEC_SEL0             = 16'h0200;
	localparam logic [15:0] VEC_SEL1             = 16'h0300;
	localparam logic [15:0] VEC_SEL2             = 16'h0400;
	localparam logic [15:0] VEC_SEL3             = 16'h0500;
	// option byte fields
	localparam int         OPT_VEC_OFF           = 7;
	localparam int         OPT_VEC_LSB           = 5;
	localparam int         OPT_BOOT_OFF          = 2;
	localparam int         OPT_BOOT_DIS          = 1;
	// erase time
	localparam int unsigned ERASE_TIME_MS        = 10;
	localparam int unsigned CLK_HZ               = 100_000_000;
	localparam int unsigned ERASE_CYCLES         = ERASE_TIME_MS * (CLK_HZ / 1000);
	localparam int          ERASE_CNT_W          = 20;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fupc_reg_req_t;

	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} fupc_ldc_req_t;

	typedef struct packed {
		logic        stb;
		logic [15:0] addr;
		logic [7:0]  data;
	} fupc_prog_t;

	typedef enum logic [1:0] {
		FUPC_IDLE,
		FUPC_ERASE,
		FUPC_LOCK
	} fupc_state_t;
endpackage

/* fupc_timer.sv */
// fupc_timer: run counter flagging when a limit is reached
// assumes start and clear are one-cycle pulses from the sequencer
`timescale 1ns/1ns
module fupc_timer #(
	parameter int W = 20
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic         clear,
	input  wire logic [W-1:0] limit,
	output logic              done
);
	logic [W-1:0] cnt_r;
	logic         run_r;

	// counter runs from start until limit or clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else if (clear) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else if (start) begin
			cnt_r <= '0;
			run_r <= 1'b1;
		end else if (run_r) begin
			cnt_r <= cnt_r + 1'b1;
			if (cnt_r == limit - 1'b1)
				run_r <= 1'b0;
		end
	end

	// one-cycle flag when the count completes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			done <= 1'b0;
		else
			done <= run_r && !clear && !start && (cnt_r == limit - 1'b1);
	end
endmodule // fupc_timer

/* fupc_top.sv */
// fupc_top: flash user-program guard, sector select, erase sequencer
// assumes cpu register port and load-instruction writes synchronous to clk
`timescale 1ns/1ns
module fupc_top
	import fupc_pkg::*;
#(
	parameter int          NIRQ      = 8,
	parameter int unsigned ERASE_CYC = fupc_pkg::ERASE_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  fupc_pkg::fupc_reg_req_t    reg_req,
	output logic [7:0]                 reg_rdata_r,
	input  fupc_pkg::fupc_ldc_req_t    ldc_req,
	output fupc_pkg::fupc_prog_t       prog_r,
	input  wire logic [7:0]            option_byte,
	input  wire logic                  tool_mode,
	input  wire logic                  tool_chip_erase,
	input  wire logic [NIRQ-1:0]       irq_enable,
	input  wire logic [NIRQ-1:0]       irq_pending,
	input  wire logic [NIRQ-1:0]       interrupt_mask_register,
	output logic                       int_take_r,
	output logic                       erase_busy_r,
	output logic [15:0]                erase_base_r,
	output logic                       hard_lock_r,
	output logic                       user_mode_r,
	output logic [15:0]                reset_vec_r,
	output logic [15:0]                boot_end_r,
	output logic                       boot_on_r
);
	import fupc_pkg::*;

	fupc_state_t state_r;
	logic [7:0]  user_program_key_r;
	logic [7:0]  sector_base_high_r;
	logic [7:0]  sector_base_low_r;
	logic [3:0]  op_mode_r;
	logic        op_status_r;
	logic        flash_op_start_r;
	logic [7:0]  opt_r;
	logic        opt_cap_r;
	logic        tmr_done;
	logic        tmr_start;
	logic        tmr_clear;
	logic [15:0] sec_base;
	logic        sec_valid;
	logic        key_ok;
	logic        wr_ctl;
	logic        irq_req;
	logic        erase_ok;
	logic        erase_go;
	logic        erase_bad;
	logic        lock_go;
	logic        erase_end;
	logic        erase_abort;
	logic        prog_ok;
	logic        sec_in_boot;
	logic        ldc_in_boot;

	localparam logic [ERASE_CNT_W-1:0] ERASE_LIMIT = ERASE_CNT_W'(ERASE_CYC);

	assign key_ok    = (user_program_key_r == KEY_VALUE);
	assign sec_base  = {sector_base_high_r, sector_base_low_r[7], 7'h00};
	assign sec_valid = (sec_base[15:SECTOR_BITS] < SECTOR_COUNT);
	assign wr_ctl    = reg_req.wr && (reg_req.addr == ADDR_FLASH_OP_CONTROL);
	assign irq_req   = |(irq_enable & irq_pending);

	// boot-loader region test, bypassed in tool mode
	assign sec_in_boot = boot_on_r && !tool_mode && (sec_base >= BOOT_START)
		&& (sec_base <= boot_end_r);
	assign ldc_in_boot = boot_on_r && !tool_mode && (ldc_req.addr >= BOOT_START)
		&& (ldc_req.addr <= boot_end_r);

	// erase request decode
	assign erase_ok  = key_ok && !hard_lock_r && !tool_mode && sec_valid && !sec_in_boot;
	assign erase_go  = wr_ctl && reg_req.wdata[CTL_START_BIT] && (state_r == FUPC_IDLE)
		&& (reg_req.wdata[7:CTL_MODE_LSB] == MODE_SECTOR_ERASE) && erase_ok;
	assign erase_bad = wr_ctl && reg_req.wdata[CTL_START_BIT] && (state_r == FUPC_IDLE)
		&& (reg_req.wdata[7:CTL_MODE_LSB] == MODE_SECTOR_ERASE) && !erase_ok;
	assign lock_go   = wr_ctl && reg_req.wdata[CTL_START_BIT] && (state_r == FUPC_IDLE)
		&& (reg_req.wdata[7:CTL_MODE_LSB] == MODE_HARD_LOCK) && key_ok;
	assign erase_abort = (state_r == FUPC_ERASE) && irq_req;
	assign erase_end   = (state_r == FUPC_ERASE) && tmr_done && !irq_req;
	assign tmr_start   = erase_go;
	assign tmr_clear   = erase_abort;

	// programming write decode
	assign prog_ok = ldc_req.wr && key_ok && !hard_lock_r && (state_r == FUPC_IDLE)
		&& (op_mode_r == MODE_PROGRAM)
		&& (ldc_req.addr[15:SECTOR_BITS] == sec_base[15:SECTOR_BITS])
		&& sec_valid && !ldc_in_boot;

	fupc_timer #(
		.W     (ERASE_CNT_W)
	) u_erase_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.start (tmr_start),
		.clear (tmr_clear),
		.limit (ERASE_LIMIT),
		.done  (tmr_done)
	);

	// option byte caught once after reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			opt_r     <= 8'hff;
			opt_cap_r <= 1'b0;
		end else if (!opt_cap_r) begin
			opt_r     <= option_byte;
			opt_cap_r <= 1'b1;
		end
	end

	// reset vector decode from bits 7..5
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_vec_r <= VEC_DEFAULT;
		end else if (opt_r[OPT_VEC_OFF]) begin
			reset_vec_r <= VEC_DEFAULT;
		end else begin
			case (opt_r[OPT_VEC_LSB+1:OPT_VEC_LSB])
				2'h0:    reset_vec_r <= VEC_SEL0;
				2'h1:    reset_vec_r <= VEC_SEL1;
				2'h2:    reset_vec_r <= VEC_SEL2;
				2'h3:    reset_vec_r <= VEC_SEL3;
				default: reset_vec_r <= VEC_DEFAULT;
			endcase
		end
	end

	// boot region size decode from bits 2..0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_on_r  <= 1'b0;
			boot_end_r <= BOOT_END_256;
		end else begin
			boot_on_r <= !opt_r[OPT_BOOT_OFF];
			case (opt_r[OPT_BOOT_DIS:0])
				2'h0:    boot_end_r <= BOOT_END_256;
				2'h1:    boot_end_r <= BOOT_END_512;
				2'h2:    boot_end_r <= BOOT_END_1K;
				2'h3:    boot_end_r <= BOOT_END_2K;
				default: boot_end_r <= BOOT_END_256;
			endcase
		end
	end

	// guard register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			user_program_key_r <= RESET_BYTE;
		else if (reg_req.wr && (reg_req.addr == ADDR_USER_PROGRAM_KEY))
			user_program_key_r <= reg_req.wdata;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			user_mode_r <= 1'b0;
		else if (reg_req.wr && (reg_req.addr == ADDR_USER_PROGRAM_KEY))
			user_mode_r <= (reg_req.wdata == KEY_VALUE);
	end

	// sector base registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sector_base_high_r <= RESET_BYTE;
			sector_base_low_r  <= RESET_BYTE;
		end else if (reg_req.wr) begin
			if (reg_req.addr == ADDR_SECTOR_BASE_HIGH)
				sector_base_high_r <= reg_req.wdata;
			if (reg_req.addr == ADDR_SECTOR_BASE_LOW)
				sector_base_low_r <= reg_req.wdata;
		end
	end

	// mode field
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			op_mode_r <= 4'h0;
		else if (wr_ctl)
			op_mode_r <= reg_req.wdata[7:CTL_MODE_LSB];
	end

	// sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= FUPC_IDLE;
		end else begin
			case (state_r)
				FUPC_IDLE: begin
					if (erase_go)
						state_r <= FUPC_ERASE;
					else if (lock_go)
						state_r <= FUPC_LOCK;
				end
				FUPC_ERASE: begin
					if (erase_abort || erase_end)
						state_r <= FUPC_IDLE;
				end
				FUPC_LOCK: state_r <= FUPC_IDLE;
				default:   state_r <= FUPC_IDLE;
			endcase
		end
	end

	// start bit, self-clearing on completion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			flash_op_start_r <= 1'b0;
		else if (erase_abort || erase_end || (state_r == FUPC_LOCK) || erase_bad)
			flash_op_start_r <= 1'b0;
		else if (wr_ctl && (state_r == FUPC_IDLE))
			flash_op_start_r <= reg_req.wdata[CTL_START_BIT] && (erase_go || lock_go);
	end

	// erase status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			op_status_r <= 1'b0;
		else if (erase_abort || erase_bad)
			op_status_r <= 1'b1;
		else if (erase_end)
			op_status_r <= 1'b0;
	end

	// erase outputs to the flash macro
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			erase_busy_r <= 1'b0;
			erase_base_r <= 16'h0000;
		end else begin
			if (erase_go) begin
				erase_busy_r <= 1'b1;
				erase_base_r <= sec_base;
			end else if (erase_abort || erase_end) begin
				erase_busy_r <= 1'b0;
			end
		end
	end

	// hard lock, released only by tool chip erase or by reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hard_lock_r <= 1'b0;
		else if (state_r == FUPC_LOCK)
			hard_lock_r <= 1'b1;
		else if (tool_mode && tool_chip_erase)
			hard_lock_r <= 1'b0;
	end

	// programming strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_r <= '0;
		end else begin
			prog_r.stb <= prog_ok;
			if (prog_ok) begin
				prog_r.addr <= ldc_req.addr;
				prog_r.data <= ldc_req.data;
			end
		end
	end

	// interrupt service: mask ignored while erasing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			int_take_r <= 1'b0;
		else if (state_r == FUPC_ERASE)
			int_take_r <= irq_req;
		else
			int_take_r <= |(irq_enable & irq_pending & interrupt_mask_register);
	end

	// register read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				ADDR_FLASH_OP_CONTROL: reg_rdata_r <= {op_mode_r, op_status_r, 2'b00, flash_op_start_r};
				ADDR_USER_PROGRAM_KEY: reg_rdata_r <= user_program_key_r;
				ADDR_SECTOR_BASE_HIGH: reg_rdata_r <= sector_base_high_r;
				ADDR_SECTOR_BASE_LOW:  reg_rdata_r <= sector_base_low_r;
				default:               reg_rdata_r <= 8'h00;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_key_enable: assert property (
		reg_req.wr && (reg_req.addr == ADDR_USER_PROGRAM_KEY) |=>
		user_mode_r == ($past(reg_req.wdata) == KEY_VALUE)
	) else $error("guard key did not set user mode");

	a_irq_unmasked: assert property (
		(state_r == FUPC_ERASE) && irq_req |=> int_take_r
	) else $error("interrupt not serviced during erase");

	a_irq_abort: assert property (
		erase_busy_r && (state_r == FUPC_ERASE) && irq_req |=>
		!erase_busy_r && op_status_r && !flash_op_start_r
	) else $error("erase not abandoned on interrupt");

	a_erase_success: assert property (
		$fell(erase_busy_r) && !op_status_r |-> $past(tmr_done)
	) else $error("erase reported success without completing");

	a_sector_base: assert property (
		$rose(erase_busy_r) |->
		erase_base_r == {$past(sector_base_high_r), $past(sector_base_low_r[7]), 7'h00}
	) else $error("erase base not formed from sector registers");

	a_prog_sector: assert property (
		prog_r.stb |-> prog_r.addr[15:7] == {$past(sector_base_high_r), $past(sector_base_low_r[7])}
	) else $error("program write outside selected sector");

	a_prog_boot: assert property (
		prog_r.stb && $past(boot_on_r) && !$past(tool_mode) |->
		(prog_r.addr < BOOT_START) || (prog_r.addr > $past(boot_end_r))
	) else $error("program write into protected boot region");

	a_tool_no_erase: assert property (
		$rose(erase_busy_r) |-> !$past(tool_mode)
	) else $error("erase started in tool mode");

	a_lock_blocks: assert property (
		hard_lock_r |=> !prog_r.stb && !$rose(erase_busy_r)
	) else $error("flash changed under hard lock");

	a_lock_start_clr: assert property (
		lock_go |=> ##1 hard_lock_r && !flash_op_start_r
	) else $error("hard lock start bit did not clear");

	a_key_gate: assert property (
		$rose(erase_busy_r) |-> $past(key_ok)
	) else $error("erase started without key");

	c_erase_done: cover property ($fell(erase_busy_r) && !op_status_r);
	c_erase_abort: cover property (erase_abort);
	c_prog_write: cover property (prog_r.stb);
	c_hard_lock: cover property ($rose(hard_lock_r));
endmodule // fupc_top

/* fupc_flash_model.sv */
// fupc_flash_model: flash array behind the program strobe
// assumes prog is registered on clk by the design
`timescale 1ns/1ns
module fupc_flash_model (
	input  wire logic          clk,
	input  fupc_pkg::fupc_prog_t prog,
	output int                 writes,
	output logic [15:0]        last_addr,
	output logic [7:0]         last_data
);
	import fupc_pkg::*;

	// 384 sectors of 128 bytes, erased state ffh
	logic [7:0] mem [0:384*128-1];

	initial begin
		writes = 0;
		last_addr = 16'h0000;
		last_data = 8'h00;
		foreach (mem[i]) mem[i] = 8'hff;
	end

	always @(posedge clk) begin
		if (prog.stb && prog.addr <= 16'hbfff) begin
			mem[prog.addr] <= prog.data;
			writes <= writes + 1;
			last_addr <= prog.addr;
			last_data <= prog.data;
		end
	end
endmodule // fupc_flash_model

/* fupc_top_tb.sv */
// fupc_top_tb: register-level tests of the flash user-program block
// assumes the flash model as far side and a short erase count
`timescale 1ns/1ns
module fupc_top_tb;
	import fupc_pkg::*;

	logic          clk, rst_n, tool_mode, tool_chip_erase;
	fupc_reg_req_t req;
	fupc_ldc_req_t program_memory_load_instruction;
	fupc_prog_t    prog;
	logic [7:0]    opt, rdata, ien, ipend, imask, la_d;
	logic          int_take, busy, lock, umode, boot_on;
	logic [15:0]   base, vec, boot_end, la;
	int            writes, n;
	int            failures = 0;
	int            checks_done = 0;
	int            cyc = 0;
	logic [7:0]    otab [3] = '{8'h04, 8'h83, 8'h41};
	logic [15:0]   vtab [3] = '{VEC_SEL0, VEC_DEFAULT, VEC_SEL2};
	logic [15:0]   etab [3] = '{BOOT_END_256, BOOT_END_2K, BOOT_END_512};
	logic          btab [3] = '{1'b0, 1'b1, 1'b1};
	localparam int ERASE_T  = 20;
	logic [7:0]    ktab [4] = '{8'ha0, 8'ha5, 8'ha5, 8'ha5};
	logic [7:0]    htab [4] = '{8'h10, 8'h01, 8'hc0, 8'h10};

	fupc_top #(.NIRQ(8), .ERASE_CYC(ERASE_T)) u_dut (
		.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata_r(rdata),
		.ldc_req(program_memory_load_instruction), .prog_r(prog), .option_byte(opt),
		.tool_mode(tool_mode), .tool_chip_erase(tool_chip_erase),
		.irq_enable(ien), .irq_pending(ipend), .interrupt_mask_register(imask),
		.int_take_r(int_take), .erase_busy_r(busy), .erase_base_r(base),
		.hard_lock_r(lock), .user_mode_r(umode), .reset_vec_r(vec),
		.boot_end_r(boot_end), .boot_on_r(boot_on)
	);

	fupc_flash_model u_flash (
		.clk(clk), .prog(prog), .writes(writes), .last_addr(la), .last_data(la_d)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
	endtask

	task automatic pgm(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		program_memory_load_instruction = '{wr: 1'b1, addr: a, data: d};
		@(negedge clk);
		program_memory_load_instruction.wr = 1'b0;
	endtask

	task automatic sel(input logic [7:0] key, input logic [7:0] hi, input logic [7:0] lo);
		wr(ADDR_USER_PROGRAM_KEY, key);
		wr(ADDR_SECTOR_BASE_HIGH, hi);
		wr(ADDR_SECTOR_BASE_LOW, lo);
	endtask

	// good erase of sector 1780h, then control read back
	task automatic erase_run();
		sel(KEY_VALUE, 8'h17, 8'h80);
		wr(ADDR_FLASH_OP_CONTROL, 8'ha1);
		repeat (ERASE_T + 3) @(negedge clk);
		rd(ADDR_FLASH_OP_CONTROL);
	endtask

	initial begin
		rst_n = 1'b0;
		req = '0;
		program_memory_load_instruction = '0;
		opt = 8'h00;
		tool_mode = 1'b0;
		tool_chip_erase = 1'b0;
		ien = 8'h00;
		ipend = 8'h00;
		imask = 8'h00;
		// option decode and reset values
		foreach (otab[i]) begin
			opt = otab[i];
			rst_n = 1'b0;
			repeat (20) @(negedge clk);
			rst_n = 1'b1;
			repeat (3) @(negedge clk);
			chk("reset_vec", vec, vtab[i]);
			chk("boot_on", boot_on, btab[i]);
			chk("boot_end", boot_end, etab[i]);
			chk("user_mode", umode, 0);
			rd(ADDR_USER_PROGRAM_KEY);
			chk("key reset", rdata, 8'h00);
		end
		chk("boot_end", boot_end, BOOT_END_512);
		$display("test options done");
		// guard key
		wr(ADDR_USER_PROGRAM_KEY, KEY_VALUE);
		chk("user_mode", umode, 1);
		wr(ADDR_USER_PROGRAM_KEY, 8'ha4);
		chk("user_mode", umode, 0);
		$display("test key done");
		// program inside and outside the selected sector
		sel(KEY_VALUE, 8'h17, 8'hff);
		rd(ADDR_SECTOR_BASE_LOW);
		chk("sector low", rdata, 8'hff);
		wr(ADDR_FLASH_OP_CONTROL, 8'h50);
		pgm(16'h1784, 8'h78);
		chk("prog stb", prog.stb, 1);
		chk("prog addr", prog.addr, 16'h1784);
		pgm(16'h1804, 8'h11);
		chk("prog stb", prog.stb, 0);
		chk("flash writes", writes, 1);
		chk("flash data", la_d, 8'h78);
		$display("test program done");
		// full sector erase
		wr(ADDR_FLASH_OP_CONTROL, 8'ha1);
		@(negedge clk);
		chk("erase_busy", busy, 1);
		chk("erase_base", base, 16'h1780);
		n = 0;
		while (busy === 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
		chk("erase long", n >= 20, 1);
		chk("erase cycles", n, ERASE_T);
		rd(ADDR_FLASH_OP_CONTROL);
		chk("control", rdata, 8'ha0);
		wr(ADDR_FLASH_OP_CONTROL, 8'h50);
		pgm(16'h17a0, 8'h3c);
		chk("prog stb", prog.stb, 1);
		$display("test erase done");
		// interrupt aborts erase with all mask bits clear
		wr(ADDR_FLASH_OP_CONTROL, 8'ha1);
		@(negedge clk);
		ien = 8'h04;
		ipend = 8'h04;
		@(negedge clk);
		chk("int_take", int_take, 1);
		@(negedge clk);
		chk("erase_busy", busy, 0);
		ien = 8'h00;
		ipend = 8'h00;
		rd(ADDR_FLASH_OP_CONTROL);
		chk("control", rdata, 8'ha8);
		$display("test abort done");
		// refused erases: no key, boot sector, past last sector, tool mode
		foreach (ktab[i]) begin
			erase_run();
			chk("status", rdata[3], 0);
			sel(ktab[i], htab[i], 8'h00);
			tool_mode = (i == 3);
			wr(ADDR_FLASH_OP_CONTROL, 8'ha1);
			@(negedge clk);
			chk("erase_busy", busy, 0);
			rd(ADDR_FLASH_OP_CONTROL);
			chk("status", rdata[3], 1);
		end
		tool_mode = 1'b0;
		$display("test refuse done");
		// boot region writes: blocked in user mode, open in tool mode
		sel(KEY_VALUE, 8'h01, 8'h00);
		wr(ADDR_FLASH_OP_CONTROL, 8'h50);
		pgm(16'h0110, 8'h5a);
		chk("prog stb", prog.stb, 0);
		tool_mode = 1'b1;
		pgm(16'h0120, 8'h5b);
		chk("prog stb", prog.stb, 1);
		tool_mode = 1'b0;
		$display("test boot done");
		// hard lock, refusal, tool chip erase, reserved mode
		wr(ADDR_FLASH_OP_CONTROL, 8'h61);
		repeat (3) @(negedge clk);
		chk("hard_lock", lock, 1);
		rd(ADDR_FLASH_OP_CONTROL);
		chk("start bit", rdata[0], 0);
		sel(KEY_VALUE, 8'h17, 8'h80);
		wr(ADDR_FLASH_OP_CONTROL, 8'h50);
		pgm(16'h1790, 8'h33);
		chk("prog stb", prog.stb, 0);
		tool_mode = 1'b1;
		tool_chip_erase = 1'b1;
		repeat (2) @(negedge clk);
		tool_mode = 1'b0;
		tool_chip_erase = 1'b0;
		@(negedge clk);
		chk("hard_lock", lock, 0);
		wr(ADDR_FLASH_OP_CONTROL, 8'h31);
		@(negedge clk);
		chk("reserved busy", {busy, lock}, 0);
		$display("test lock done");
		conclude();
	end
endmodule // fupc_top_tb
